// [clk_sup_defs.vh]
// Constants for the clock supervisor counter block.
`ifndef CLK_SUP_DEFS_VH
`define CLK_SUP_DEFS_VH
`define CTRL_OFFSET     12'hFE9
`define RESULT_OFFSET   12'hFEA
`define CTRL_IDX        12'hFE9
`define RESULT_IDX      12'hFEA
`define CTRL_ENABLE_BIT 0
`define CTRL_WIN_LSB    1
`define CTRL_WIN_MSB    3
`define CTRL_SRC_BIT    4
`define CTRL_RESET      8'h00
`define RESULT_RESET    8'h00
`define CTRL_WMASK      8'h1F
`define STOP_EDGES      2'h2
`endif

// [clk_sync.v]
// Two-flop synchroniser with rising and falling edge detection on the synchronised level.
`timescale 1ns/10ps
`default_nettype none
module clk_sync (
    input  wire ref_clk_i,  // System clock.
    input  wire rstn_i,     // Asynchronous reset, active low.
    input  wire d_i,        // Asynchronous level.
    output wire q_o,        // Synchronised level.
    output wire rise_o,     // One-cycle pulse on a rising edge.
    output wire fall_o      // One-cycle pulse on a falling edge.
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end
    assign q_o    = s2;
    assign rise_o = s2 & ~s3;
    assign fall_o = ~s2 & s3;
endmodule
`default_nettype wire

// [clk_sup.v]
// Clock supervisor counter with APB control and result registers.
// Behaviour
// RULE1: Result register holds the count reached when counting stopped.
// RULE2: Result register clears to zero on system reset.
// RULE3: Enable going zero to one clears the result and starts measuring.
// RULE4: Enable going one to zero while running clears the result.
// RULE5: Two window falling edges after the external clock stops clear the result.
// RULE6: Result reads zero while the counter runs with enable set.
// RULE7: Software compares the read count against the selected window interval.
// RULE8: Writes to the result register are ignored.
// RULE9: Software selects the window from eight time-base intervals.
// RULE10: Software selects main or sub oscillation clock as count source.
// RULE11: Counter advances by window interval or by external clock edges; the code advances it only on selected source clock edges while counting.
`timescale 1ns/10ps
`default_nettype none
`include "clk_sup_defs.vh"
module clk_sup (
    input  wire        ref_clk_i,    // System clock, 100 MHz.
    input  wire        rstn_i,       // Asynchronous reset, active low.
    input  wire        psel,         // APB select.
    input  wire        penable,      // APB enable.
    input  wire        pwrite,       // APB direction, high for write.
    input  wire [13:0] paddr,        // APB byte address.
    input  wire [31:0] pwdata,       // APB write data.
    output wire        pready,       // APB ready, always high.
    output wire        pslverr,      // APB error on unmapped address.
    output wire [31:0] prdata,       // APB read data.
    input  wire [7:0]  tbt_i,        // Time-base timer interval outputs.
    input  wire        main_osc_i,   // Main oscillation clock.
    input  wire        sub_osc_i,    // Sub-oscillation clock.
    output wire        running_o     // Counter is measuring.
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_WAIT  = 3'b010;
    localparam ST_COUNT = 3'b100;

    reg  [7:0] ctrl;
    reg  [7:0] result;
    reg  [7:0] count;
    reg  [2:0] state;
    reg  [2:0] next_state;
    reg  [1:0] idle_falls;
    reg  [31:0] rdata;
    wire [7:0] tbt_q;
    wire [7:0] tbt_fall;
    wire       main_rise;
    wire       sub_rise;
    wire       main_q;
    wire       sub_q;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_tbt
            clk_sync u_sync (
                .ref_clk_i (ref_clk_i),
                .rstn_i    (rstn_i),
                .d_i       (tbt_i[g]),
                .q_o       (tbt_q[g]),
                .rise_o    (),
                .fall_o    (tbt_fall[g])
            );
        end
    endgenerate
    clk_sync u_main (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .d_i       (main_osc_i),
        .q_o       (main_q),
        .rise_o    (main_rise),
        .fall_o    ()
    );
    clk_sync u_sub (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .d_i       (sub_osc_i),
        .q_o       (sub_q),
        .rise_o    (sub_rise),
        .fall_o    ()
    );

    wire [2:0] win_sel  = ctrl[`CTRL_WIN_MSB:`CTRL_WIN_LSB]; // RULE9
    wire       win_fall = tbt_fall[win_sel];                 // RULE9
    wire       src_edge = ctrl[`CTRL_SRC_BIT] ? sub_rise : main_rise; // RULE10
    wire       enable   = ctrl[`CTRL_ENABLE_BIT];

    wire wr_acc  = psel & penable & pwrite;
    wire hit_ctl = (paddr == {`CTRL_OFFSET, 2'b00});
    wire hit_res = (paddr == {`RESULT_OFFSET, 2'b00});
    wire mapped  = hit_ctl | hit_res;
    wire ctl_wr  = wr_acc & hit_ctl;
    wire [7:0] new_ctrl = pwdata[7:0] & `CTRL_WMASK;
    wire en_rise = ctl_wr & ~enable & new_ctrl[`CTRL_ENABLE_BIT];
    wire en_fall = ctl_wr & enable & ~new_ctrl[`CTRL_ENABLE_BIT];

    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~mapped;
    assign prdata    = rdata;
    assign running_o = (state != ST_IDLE);

    // Hardware drops the enable bit itself when the window closes.
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl <= `CTRL_RESET;
        end else begin
            if (ctl_wr) begin
                ctrl <= new_ctrl;
            end
            // The stop edge wins over a write that keeps the enable bit set.
            if (state == ST_COUNT && win_fall) begin
                ctrl[`CTRL_ENABLE_BIT] <= 1'b0;
            end
        end
    end

    // First window falling edge starts counting, the second stops it.
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (en_rise) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (en_fall) begin
                    next_state = ST_IDLE;
                end else if (win_fall) begin
                    next_state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (en_fall || win_fall) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state      <= ST_IDLE;
            count      <= 8'h00;
            result     <= `RESULT_RESET;            // RULE2
            idle_falls <= 2'h0;
        end else begin
            state <= next_state;
            if (en_rise) begin
                count      <= 8'h00;
                result     <= 8'h00;                // RULE3
                idle_falls <= 2'h0;
            end else if (en_fall) begin
                result <= 8'h00;                    // RULE4
                count  <= 8'h00;
            end else if (state == ST_COUNT) begin
                result <= 8'h00;                    // RULE6
                if (win_fall) begin
                    result     <= count;            // RULE1
                    idle_falls <= 2'h0;
                end else if (src_edge && count != 8'hFF) begin
                    count <= count + 8'h01;         // RULE11
                end
            end else if (state == ST_WAIT) begin
                result <= 8'h00;                    // RULE6
            end else if (src_edge) begin
                idle_falls <= 2'h0;
            end else if (win_fall && idle_falls != `STOP_EDGES) begin
                idle_falls <= idle_falls + 2'h1;
                if (idle_falls + 2'h1 == `STOP_EDGES) begin
                    result <= 8'h00;                // RULE5
                end
            end
        end
    end

    // The result register has no write path at all.
    always @* begin
        rdata = 32'h00000000;
        if (hit_ctl) begin
            rdata[7:0] = ctrl;
        end else if (hit_res) begin
            rdata[7:0] = result;                    // RULE8
        end
    end

    wire unused_ok = &{1'b0, tbt_q, main_q, sub_q, pwdata[31:8]};
endmodule
`default_nettype wire

// [clk_sup_assertions.sv]
// Port checker for the clock supervisor, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module clk_sup_chk (
    input wire logic        ref_clk_i, // Clock.
    input wire logic        rstn_i,    // Reset.
    input wire logic        psel,      // Select.
    input wire logic        penable,   // Enable.
    input wire logic        pwrite,    // Write.
    input wire logic [13:0] paddr,     // Address.
    input wire logic [31:0] pwdata,    // Write data.
    input wire logic        pready,    // Ready.
    input wire logic        pslverr,   // Error.
    input wire logic [31:0] prdata,    // Read data.
    input wire logic        running_o  // Measuring.
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    wire logic acc = psel && penable;
    wire logic res = paddr == 14'h3FA8;
    wire logic rd_res = psel && res && !pwrite;
    wire logic ctl_wr = acc && pwrite && paddr == 14'h3FA4;
    sequence start_s; ctl_wr && pwdata[0] && !running_o; endsequence
    sequence stop_s; ctl_wr && !pwdata[0] && running_o; endsequence
    a_result_upper_zero: assert property (rd_res |-> prdata[31:8] == 24'h0)
        else $error("result upper bits not zero");
    a_busy_reads_zero: assert property (running_o && rd_res |-> prdata == 32'h0)
        else $error("result nonzero while measuring");
    a_start_runs: assert property (start_s |=> running_o [*2])
        else $error("enable did not start measuring");
    a_start_clears: assert property (start_s ##1 rd_res |-> prdata == 32'h0)
        else $error("result not cleared on start");
    a_stop_idles: assert property (stop_s |=> !running_o)
        else $error("disable did not stop measuring");
    a_stop_clears: assert property (stop_s ##1 rd_res |-> prdata == 32'h0)
        else $error("result not cleared on stop");
    a_result_no_err: assert property (acc && res |-> pready && !pslverr)
        else $error("result access refused");
    a_result_wr_keeps: assert property (acc && pwrite && res && !running_o |=> !running_o)
        else $error("result write changed state");
endmodule
bind clk_sup clk_sup_chk clk_sup_chk_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .running_o(running_o));
`default_nettype wire

// [tb.sv]
// Self-checking testbench for the clock supervisor.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb;
    logic ref_clk_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic main_osc_i = 1'b0, sub_osc_i = 1'b0, pready, pslverr, running_o, er;
    logic [13:0] paddr = 14'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] tbt_i = 8'h00;
    int n_errors = 0, compares = 0, cyc = 0;
    clk_sup clk_sup_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .tbt_i(tbt_i), .main_osc_i(main_osc_i),
        .sub_osc_i(sub_osc_i), .running_o(running_o));
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // Leaves the bus in access phase so that a following call runs back to back.
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
    endtask
    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic fall(input int w);
        tbt_i[w] <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        tbt_i[w] <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
    endtask
    // One source period of eight clocks; the sub clock follows s.
    task automatic pulse(input logic s);
        main_osc_i <= 1'b1;
        sub_osc_i <= s;
        repeat (4) @(posedge ref_clk_i);
        main_osc_i <= 1'b0;
        sub_osc_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
    endtask
    // The sub clock pulses on every other main pulse, so a wrong source shows.
    task automatic measure(input int w, input int n);
        apb(1'b1, 14'h3FA4, {27'h0, w[0], w[2:0], 1'b1});
        apb(1'b0, 14'h3FA8, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(running_o, 1'b1)
        idle(2);
        fall(w);
        for (int i = 0; i < n; i++) begin
            pulse(!i[0]);
        end
        fall(w);
        idle(4);
        apb(1'b1, 14'h3FA8, 32'hFF);
        apb(1'b0, 14'h3FA8, 32'h0);
        `CHK(rd, 32'(w[0] ? (n + 1) / 2 : n))
        idle(1);
        fall(w);
        fall(w);
        apb(1'b0, 14'h3FA8, 32'h0);
        `CHK(rd, 32'h0)
        idle(1);
    endtask
    // Restart over a nonzero result, then abort a run while it counts.
    task automatic abort_run;
        apb(1'b1, 14'h3FA4, 32'h1);
        idle(1);
        fall(0);
        repeat (2) pulse(1'b0);
        fall(0);
        apb(1'b0, 14'h3FA8, 32'h0);
        `CHK(rd, 32'h2)
        apb(1'b1, 14'h3FA4, 32'h1);
        apb(1'b0, 14'h3FA8, 32'h0);
        `CHK(rd, 32'h0)
        idle(1);
        fall(0);
        repeat (2) pulse(1'b0);
        apb(1'b0, 14'h3FA8, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(running_o, 1'b1)
        apb(1'b1, 14'h3FA4, 32'h0);
        apb(1'b0, 14'h3FA8, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(running_o, 1'b0)
        idle(2);
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        @(posedge ref_clk_i);
        apb(1'b0, 14'h3FA8, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 14'h0000, 32'h0);
        `CHK(er, 1'b1)
        idle(1);
        for (int w = 0; w < 8; w++) measure(w, w + 3);
        abort_run();
        end_sim();
    end
endmodule
`default_nettype wire
